// File: hw/usbcs_ctl.sv
// control request sequencer, string server and statistics counters
`timescale 1ns/100ps
`default_nettype none
module usbcs_ctl
	import usbcs_pkg::*;
#(
	parameter bit LATER_VARIANT = 1'b1,
	parameter int EE_AW         = 9
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	// setup packet from the usb_device_core
	input  wire logic             setup_valid,
	input  wire logic [7:0]       bm_request_type,
	input  wire logic [7:0]       b_request,
	input  wire logic [15:0]      w_value,
	input  wire logic [15:0]      w_index,
	input  wire logic [15:0]      w_length,
	output logic                  busy,
	output logic                  stall_pulse,
	output logic                  ack_pulse,
	output logic                  desc_pass,
	output logic                  req_pass,
	// data stage bytes toward the host
	output logic                  data_valid,
	output logic [7:0]            data_byte,
	output logic                  data_last,
	input  wire logic             data_ready,
	// EEPROM byte read port
	input  wire logic             ee_present,
	output logic                  ee_rd,
	output logic [EE_AW-1:0]      ee_addr,
	input  wire logic [7:0]       ee_rdata,
	// receive frame status from the rx_fifo_controller
	input  wire logic             rx_done,
	input  wire logic [13:0]      rx_len,
	input  wire logic             rx_crc_err,
	input  wire logic             rx_dribble,
	input  wire logic             rx_late_coll,
	input  wire logic             rx_phy_err,
	input  wire logic             rx_fifo_drop,
	// transmit frame status
	input  wire logic             tx_done,
	input  wire logic             tx_pause,
	input  wire logic [4:0]       tx_coll_cnt,
	input  wire logic             tx_exc_coll,
	input  wire logic             tx_late_coll,
	input  wire logic             tx_underrun,
	input  wire logic             tx_exc_defer,
	input  wire logic             tx_carrier_err,
	// register port
	input  wire logic [3:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic [31:0]           reg_rdata,
	// feature state
	output logic                  remote_wakeup_en,
	output logic [3:0]            ep_halt
);
	usbcs_state_t state;            // sequencer state
	logic         src_stats;        // emitting statistics bytes
	logic [15:0]  byte_cnt;         // bytes handed over so far
	logic [15:0]  total;            // bytes in this data stage
	logic [7:0]   str_len;          // stored string length
	logic [7:0]   cfg_value;        // current configuration
	logic [13:0]  max_frame;        // programmed maximum frame size
	logic [EE_AW-1:0] rd_ptr;       // next EEPROM string byte
	logic [31:0]  snap [NUM_SNAP];  // statistics snapshot
	logic [31:0]  cnt_ext [NUM_CNT];// live counters
	logic [NUM_CNT-1:0] cnt_inc;    // one hit per counter
	logic [NUM_CNT-1:0] cnt_clr;    // read-clear strobes
	logic         take;             // setup accepted this cycle
	logic         stats_req;        // statistics request decoded
	logic         stats_tx;         // transmit bank chosen
	logic [15:0]  next_cnt;         // byte count after handover
	logic [7:0]   stats_byte;       // snapshot byte at next_cnt
	logic [15:0]  stats_len;        // full statistics length
	logic         rx_too_long;      // frame over the maximum
	logic         rx_err;           // any receive error
	logic         rx_kept;          // frame not dropped
	logic         tx_abort;         // any abort cause
	logic         tx_ok;            // frame sent without abort

	// request decode helpers
	assign take      = setup_valid && (state == ST_IDLE);
	assign stats_req = (bm_request_type == RT_VND_IN) && (b_request == RQ_GET_STATS);
	assign stats_tx  = w_index[0];
	assign stats_len = stats_tx ? STATS_TX_LEN : STATS_RX_LEN;
	assign busy      = (state != ST_IDLE);
	assign next_cnt  = byte_cnt + 16'h0001;
	assign data_last = data_valid && (next_cnt == total);

	// snapshot byte, little endian within each word
	always_comb begin
		logic [31:0] w;
		w = 32'h0000_0000;
		if (next_cnt[5:2] < 4'(NUM_SNAP)) begin
			w = snap[next_cnt[5:2]];
		end
		stats_byte = w[8*next_cnt[1:0] +: 8];
	end

	// receive classification
	assign rx_too_long = rx_len > max_frame;
	assign rx_err  = rx_crc_err || rx_too_long || rx_late_coll || rx_phy_err;
	assign rx_kept = rx_done && !rx_fifo_drop;
	// transmit classification
	assign tx_abort = tx_exc_coll || tx_late_coll || tx_underrun || tx_exc_defer;
	assign tx_ok    = tx_done && !tx_abort;

	// counter hit map
	always_comb begin
		cnt_inc     = '0;
		cnt_inc[0]  = rx_done && !rx_err;
		cnt_inc[1]  = rx_kept && rx_crc_err && !rx_dribble;
		cnt_inc[2]  = rx_kept && rx_crc_err && (rx_len < RUNT_LEN);
		cnt_inc[3]  = rx_kept && rx_crc_err && rx_dribble;
		cnt_inc[4]  = rx_kept && rx_too_long;
		cnt_inc[5]  = rx_kept && rx_late_coll;
		cnt_inc[6]  = rx_kept && rx_err;
		cnt_inc[7]  = rx_done && rx_fifo_drop;
		cnt_inc[8]  = tx_ok && !tx_pause;
		cnt_inc[9]  = tx_ok && tx_pause;
		cnt_inc[10] = tx_ok && (tx_coll_cnt == 5'h01);
		cnt_inc[11] = tx_ok && (tx_coll_cnt > 5'h01);
		cnt_inc[12] = tx_done && tx_exc_coll;
		cnt_inc[13] = tx_done && tx_late_coll;
		cnt_inc[14] = tx_done && tx_underrun;
		cnt_inc[15] = tx_done && tx_exc_defer;
		cnt_inc[16] = tx_done && tx_carrier_err;
		cnt_inc[17] = tx_done && (tx_abort || tx_carrier_err);
	end

	// read-clear only in the earlier variant, on the chosen bank
	always_comb begin
		cnt_clr = '0;
		if (!LATER_VARIANT && take && stats_req) begin
			for (int i = 0; i < NUM_CNT; i++) begin
				cnt_clr[i] = stats_tx ? (i >= CNT_TX_GOOD) : (i < NUM_RX_CNT);
			end
		end
	end

	// counter bank; unsized counters take the narrow width
	for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
		usbcs_stat_cnt #(
			.W   ((g == CNT_RX_GOOD || g == CNT_TX_GOOD) ? WIDE : NARROW),
			.SAT (!LATER_VARIANT)
		) u_cnt (
			.clk       (clk),
			.rst_n     (rst_n),
			.inc       (cnt_inc[g]),
			.clr       (cnt_clr[g]),
			.count_ext (cnt_ext[g])
		);
	end

	// snapshot taken when a statistics request is taken
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_SNAP; i++) begin
				snap[i] <= 32'h0000_0000;
			end
		end else if (take && stats_req) begin
			for (int i = 0; i < NUM_SNAP; i++) begin
				if (stats_tx) begin
					snap[i] <= cnt_ext[CNT_TX_GOOD + i];
				end else if (i < NUM_RX_CNT) begin
					snap[i] <= cnt_ext[i];
				end else begin
					snap[i] <= 32'h0000_0000;
				end
			end
		end
	end

	// software writes to configuration and maximum frame size
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_value <= CFG_RST;
			max_frame <= MAXLEN_RST;
		end else if (reg_wr && reg_addr == REG_MAXLEN) begin
			max_frame <= reg_wdata[13:0];
		end else if (reg_wr && reg_addr == REG_CTRL) begin
			cfg_value <= reg_wdata[7:0];
		end
	end

	// remote wakeup: software sets, clear feature clears, set wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			remote_wakeup_en <= 1'b0;
		end else if (reg_wr && reg_addr == REG_CTRL) begin
			remote_wakeup_en <= reg_wdata[CTRL_RWU_BIT];
		end else if (take && b_request == RQ_CLR_FEAT && w_length == 16'h0000
				&& bm_request_type == RT_DEV_OUT) begin
			remote_wakeup_en <= 1'b0;
		end
	end

	// endpoint halts: written by software, cleared per endpoint
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ep_halt <= 4'h0;
		end else if (reg_wr && reg_addr == REG_HALT) begin
			ep_halt <= reg_wdata[3:0];
		end else if (take && b_request == RQ_CLR_FEAT && w_length == 16'h0000
				&& bm_request_type == RT_EP_OUT && w_index[3:0] < NUM_EP) begin
			ep_halt[w_index[1:0]] <= 1'b0;
		end
	end

	// register read data, one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL:   reg_rdata <= {23'h000000, remote_wakeup_en, cfg_value};
				REG_MAXLEN: reg_rdata <= {18'h00000, max_frame};
				REG_HALT:   reg_rdata <= {28'h0000000, ep_halt};
				REG_STATUS: reg_rdata <= {28'h0000000, busy, state};
				default:    reg_rdata <= 32'h0000_0000; // unmapped
			endcase
		end
	end

	// request sequencer and data stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state       <= ST_IDLE;
			src_stats   <= 1'b0;
			byte_cnt    <= 16'h0000;
			total       <= 16'h0000;
			str_len     <= 8'h00;
			rd_ptr      <= '0;
			data_valid  <= 1'b0;
			data_byte   <= 8'h00;
			stall_pulse <= 1'b0;
			ack_pulse   <= 1'b0;
			desc_pass   <= 1'b0;
			req_pass    <= 1'b0;
			ee_rd       <= 1'b0;
			ee_addr     <= '0;
		end else begin
			// pulses default low
			stall_pulse <= 1'b0;
			ack_pulse   <= 1'b0;
			desc_pass   <= 1'b0;
			req_pass    <= 1'b0;
			ee_rd       <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					byte_cnt <= 16'h0000;
					if (setup_valid) begin
						if (b_request == RQ_CLR_FEAT && w_length == 16'h0000) begin
							// device wakeup or endpoint 0-3
							if (bm_request_type == RT_DEV_OUT
									|| (bm_request_type == RT_EP_OUT
									&& w_index[3:0] < NUM_EP)) begin
								ack_pulse <= 1'b1;
							end else begin
								stall_pulse <= 1'b1;
							end
						end else if (bm_request_type == RT_DEV_IN
								&& b_request == RQ_GET_CFG) begin
							// single configuration byte
							if (w_length == 16'h0000) begin
								ack_pulse <= 1'b1;
							end else begin
								total      <= CFG_LEN;
								src_stats  <= 1'b0;
								data_byte  <= cfg_value;
								data_valid <= 1'b1;
								state      <= ST_EMIT;
							end
						end else if (bm_request_type == RT_DEV_IN
								&& b_request == RQ_GET_DESC) begin
							unique case (w_value[15:8])
								DT_STRING: begin
									if (w_value[7:0] == 8'h00) begin
										desc_pass <= 1'b1;
									end else if (!ee_present
											|| w_value[7:0] > STR_IDX_MAX) begin
										stall_pulse <= 1'b1;
									end else begin
										// fetch stored length
										ee_rd   <= 1'b1;
										ee_addr <= EE_AW'(STR_TBL_BASE)
											+ EE_AW'({w_value[7:0] - 8'h01, 1'b0});
										state   <= ST_STR_LEN;
									end
								end
								DT_DEVICE, DT_CONFIG, DT_QUAL, DT_OTHER: begin
									desc_pass <= 1'b1;
								end
								DT_IFACE, DT_EP: begin
									stall_pulse <= 1'b1;
								end
								default: begin
									stall_pulse <= 1'b1;
								end
							endcase
						end else if ((bm_request_type == RT_DEV_OUT
								&& b_request == RQ_SET_DESC)
								|| (bm_request_type == RT_EP_IN
								&& b_request == RQ_SYNCH)) begin
							stall_pulse <= 1'b1;
						end else if (stats_req) begin
							// snapshot lands this edge, bytes follow
							src_stats <= 1'b1;
							total     <= (w_length < stats_len) ? w_length : stats_len;
							state     <= ST_STATS;
						end else begin
							req_pass <= 1'b1;
						end
					end
				end
				ST_STR_LEN: begin
					// length arrives, fetch the offset next
					str_len <= ee_rdata;
					ee_rd   <= 1'b1;
					ee_addr <= ee_addr + EE_AW'(1);
					state   <= ST_STR_OFF;
				end
				ST_STR_OFF: begin
					if (str_len == 8'h00 && ee_rdata == 8'h00) begin
						stall_pulse <= 1'b1;
						state       <= ST_IDLE;
					end else if (str_len == 8'h00 || w_length == 16'h0000) begin
						ack_pulse <= 1'b1;
						state     <= ST_IDLE;
					end else begin
						// stored length used as is, only host length limits
						total     <= (w_length < {8'h00, str_len})
							? w_length : {8'h00, str_len};
						rd_ptr    <= EE_AW'(ee_rdata);
						src_stats <= 1'b0;
						state     <= ST_RD;
					end
				end
				ST_RD: begin
					// request the next stored string byte
					ee_rd   <= 1'b1;
					ee_addr <= rd_ptr;
					rd_ptr  <= rd_ptr + EE_AW'(1);
					state   <= ST_RD_WAIT;
				end
				ST_RD_WAIT: begin
					// header and characters pass untouched
					data_byte  <= ee_rdata;
					data_valid <= 1'b1;
					state      <= ST_EMIT;
				end
				ST_STATS: begin
					if (total == 16'h0000) begin
						ack_pulse <= 1'b1;
						state     <= ST_IDLE;
					end else begin
						data_byte  <= snap[0][7:0];
						data_valid <= 1'b1;
						state      <= ST_EMIT;
					end
				end
				ST_EMIT: begin
					if (data_ready) begin
						byte_cnt <= next_cnt;
						if (next_cnt == total) begin
							// last byte handed over
							data_valid <= 1'b0;
							ack_pulse  <= 1'b1;
							state      <= ST_IDLE;
						end else if (src_stats) begin
							data_byte <= stats_byte;
						end else begin
							data_valid <= 1'b0;
							state      <= ST_RD;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: hw/usbcs_stat_cnt.sv
// one statistics counter, saturating or wrapping
`timescale 1ns/100ps
`default_nettype none
module usbcs_stat_cnt #(
	parameter int W   = 20,
	parameter bit SAT = 1'b1
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        inc,
	input  wire logic        clr,
	output logic      [31:0] count_ext
);
	logic [W-1:0] count; // running value

	// a hit in the clearing cycle survives as one
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count <= '0;
		end else if (clr) begin
			count <= inc ? W'(1) : '0;
		end else if (inc) begin
			if (!(SAT && (&count))) begin
				count <= count + W'(1);
			end
		end
	end

	// zero-extend to a whole word
	assign count_ext = 32'(count);
endmodule
`default_nettype wire

// File: shared/usbcs_pkg.sv
// constants and types of the usb control request and statistics block
// Contract
// - string descriptors 1-5 use type 03h, two-byte chars
// - stall string when EEPROM absent or entry zero
// - return stored string bytes verbatim, unchecked
// - earlier variant: counters saturate, clear on read
// - later variant: snapshot on read, wrap, never clear
// - 32-bit rx good count includes fifo-dropped frames
// - crc error without dribble, alignment with dribble
// - runt counts short frames with crc error
// - count frames longer than programmed maximum
// - count rx frames with late collision
// - rx bad totals errors, excluding fifo drops
// - fifo-dropped frames counted as drops, and as rx good when error-free
// - tx good excludes pause; pause counted separately
// - count single and multiple collision tx frames
// - count each tx abort cause separately
// - count tx frames with carrier lost/absent
// - tx bad totals every errored tx frame
// - stall set descriptor and synch frame
// - clear feature: remote wakeup or endpoint halt
// - get configuration returns one configuration byte
// - get descriptor 80h/06h, serve supported types
// - stall interface and endpoint descriptor requests
// - stats read returns 20h rx, 28h tx bytes
package usbcs_pkg;
	// request type values
	localparam logic [7:0] RT_DEV_OUT = 8'h00;
	localparam logic [7:0] RT_EP_OUT  = 8'h02;
	localparam logic [7:0] RT_DEV_IN  = 8'h80;
	localparam logic [7:0] RT_EP_IN   = 8'h82;
	localparam logic [7:0] RT_VND_IN  = 8'hC0;
	// request codes
	localparam logic [7:0] RQ_CLR_FEAT  = 8'h01;
	localparam logic [7:0] RQ_GET_DESC  = 8'h06;
	localparam logic [7:0] RQ_SET_DESC  = 8'h07;
	localparam logic [7:0] RQ_GET_CFG   = 8'h08;
	localparam logic [7:0] RQ_SYNCH     = 8'h0C;
	localparam logic [7:0] RQ_GET_STATS = 8'hA2;
	// descriptor types
	localparam logic [7:0] DT_DEVICE = 8'h01;
	localparam logic [7:0] DT_CONFIG = 8'h02;
	localparam logic [7:0] DT_STRING = 8'h03;
	localparam logic [7:0] DT_IFACE  = 8'h04;
	localparam logic [7:0] DT_EP     = 8'h05;
	localparam logic [7:0] DT_QUAL   = 8'h06;
	localparam logic [7:0] DT_OTHER  = 8'h07;
	// string table and answer lengths
	localparam logic [7:0]  STR_IDX_MAX  = 8'h05;
	localparam logic [8:0]  STR_TBL_BASE = 9'h00C;
	localparam logic [15:0] CFG_LEN      = 16'h0001;
	localparam logic [15:0] STATS_RX_LEN = 16'h0020;
	localparam logic [15:0] STATS_TX_LEN = 16'h0028;
	localparam logic [3:0]  NUM_EP       = 4'h4;
	// counter slots
	localparam int CNT_RX_GOOD = 0;
	localparam int CNT_TX_GOOD = 8;
	localparam int NUM_RX_CNT  = 8;
	localparam int NUM_CNT     = 18;
	localparam int NUM_SNAP    = 10;
	localparam int WIDE        = 32;
	localparam int NARROW      = 20;
	localparam logic [13:0] RUNT_LEN = 14'h0040;
	// register map
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_MAXLEN = 4'h4;
	localparam logic [3:0] REG_HALT   = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	localparam int CTRL_RWU_BIT = 8;
	localparam logic [7:0]  CFG_RST    = 8'h00;
	localparam logic [13:0] MAXLEN_RST = 14'h05EE;
	// request sequencer states
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_STR_LEN = 3'b001,
		ST_STR_OFF = 3'b010,
		ST_RD      = 3'b011,
		ST_RD_WAIT = 3'b100,
		ST_STATS   = 3'b101,
		ST_EMIT    = 3'b110
	} usbcs_state_t;
endpackage

// File: verification/tb_usbcs_ctl.sv
// self-checking bench of the request and statistics block
`timescale 1ns/100ps
`default_nettype none
module tb_usbcs_ctl;
	import usbcs_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, setup_valid = 1'b0, ee_present = 1'b1, slow = 1'b0;
	logic [7:0] bm_request_type = 8'h00, b_request = 8'h00;
	logic [15:0] w_value = 16'h0000, w_index = 16'h0000, w_length = 16'h0000;
	logic busy, stall_pulse, ack_pulse, desc_pass, req_pass, data_valid, data_last, data_ready;
	logic ee_rd, remote_wakeup_en, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] data_byte, ee_rdata;
	logic [8:0] ee_addr;
	logic [3:0] ep_halt, reg_addr = 4'h0;
	logic [31:0] reg_rdata, reg_wdata = 32'h0, rd;
	logic rx_done = 1'b0, rx_crc_err = 1'b0, rx_dribble = 1'b0, rx_late_coll = 1'b0;
	logic rx_phy_err = 1'b0, rx_fifo_drop = 1'b0, tx_done = 1'b0, tx_pause = 1'b0;
	logic tx_exc_coll = 1'b0, tx_late_coll = 1'b0, tx_underrun = 1'b0;
	logic tx_exc_defer = 1'b0, tx_carrier_err = 1'b0;
	logic [13:0] rx_len = 14'h0000;
	logic [4:0] tx_coll_cnt = 5'h00;
	int fails = 0, samples_checked = 0, stalls = 0, acks = 0, descs = 0, reqs = 0, st, ak;
	usbcs_ctl #(.LATER_VARIANT(1'b1), .EE_AW(9)) dut (.*);
	usbcs_far_model #(.EE_AW(9)) far (.clk(clk), .ee_rd(ee_rd), .ee_addr(ee_addr),
		.ee_rdata(ee_rdata), .data_valid(data_valid), .data_byte(data_byte), .slow(slow),
		.data_ready(data_ready));
	initial begin
		forever #2 clk = ~clk;
	end
	// tally of one-cycle verdict pulses
	always @(posedge clk) begin
		if (stall_pulse === 1'b1)
			stalls++;
		if (ack_pulse === 1'b1)
			acks++;
		if (desc_pass === 1'b1)
			descs++;
		if (req_pass === 1'b1)
			reqs++;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic reg_read(input logic [3:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		rd = reg_rdata;
	endtask
	// one setup, then wait out the data and status stages
	task automatic request(input logic [7:0] rt, rq, input logic [15:0] wv, wi, wl);
		int n;
		n = 0;
		far.got.delete();
		st = stalls;
		ak = acks;
		bm_request_type <= rt;
		b_request <= rq;
		w_value <= wv;
		w_index <= wi;
		w_length <= wl;
		setup_valid <= 1'b1;
		@(posedge clk);
		setup_valid <= 1'b0;
		repeat (4) @(posedge clk);
		while (busy !== 1'b0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		repeat (2) @(posedge clk);
		check("request done", n < 3000, 1);
		st = stalls - st;
		ak = acks - ak;
	endtask
	task automatic rx(input logic [13:0] len, input logic [3:0] f);
		rx_len <= len;
		{rx_fifo_drop, rx_late_coll, rx_dribble, rx_crc_err} <= f;
		rx_done <= 1'b1;
		@(posedge clk);
		rx_done <= 1'b0;
		@(posedge clk);
	endtask
	task automatic tx(input logic [4:0] c, input logic [5:0] f);
		tx_coll_cnt <= c;
		{tx_pause, tx_exc_coll, tx_late_coll, tx_underrun, tx_exc_defer, tx_carrier_err} <= f;
		tx_done <= 1'b1;
		@(posedge clk);
		tx_done <= 1'b0;
		@(posedge clk);
	endtask
	task automatic stats(input logic bank, input logic [31:0] exp [10]);
		request(RT_VND_IN, RQ_GET_STATS, 16'h0, {15'h0, bank}, bank ? STATS_TX_LEN : STATS_RX_LEN);
		check("stat bytes", far.got.size(), bank ? 40 : 32);
		check("stat ack", ak, 1);
		for (int i = 0; i < (bank ? 10 : 8); i++)
			check("stat word", {far.got[4*i+3], far.got[4*i+2], far.got[4*i+1], far.got[4*i]}, exp[i]);
	endtask
	initial begin
		logic [3:0] ra [5] = '{4'h0, 4'h4, 4'h8, 4'h2, 4'hC};
		logic [31:0] rv [5] = '{32'h0, 32'h05EE, 32'h0, 32'h0, 32'h0};
		logic [23:0] bad [4] = '{24'h000700, 24'h820C00, 24'h800604, 24'h800605};
		logic [7:0] s [6] = '{8'h08, 8'h03, 8'h41, 8'h00, 8'h42, 8'h00};
		foreach (far.mem[i]) far.mem[i] = 8'h00;
		far.mem[12] = 8'h06;
		far.mem[13] = 8'h20;
		foreach (s[i]) far.mem[32+i] = s[i];
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (ra[i]) begin
			reg_read(ra[i]);
			check("reset value", rd, rv[i]);
		end
		$display("test registers done");
		reg_write(REG_CTRL, 32'h0101);
		reg_read(REG_CTRL);
		check("control", rd, 32'h0000_0101);
		request(RT_DEV_IN, RQ_GET_CFG, 16'h0, 16'h0, CFG_LEN);
		check("config byte", far.got[0], 8'h01);
		check("config count", far.got.size(), 1);
		check("config ack", ak, 1);
		request(RT_DEV_OUT, RQ_CLR_FEAT, 16'h0001, 16'h0, 16'h0);
		check("wakeup", remote_wakeup_en, 1'b0);
		check("wakeup ack", ak, 1);
		reg_write(REG_HALT, 32'hF);
		for (int e = 0; e < 4; e++) begin
			request(RT_EP_OUT, RQ_CLR_FEAT, 16'h0, 16'(e), 16'h0);
			check("halt", ep_halt, 4'hF & ~((4'h2 << e) - 4'h1));
		end
		foreach (bad[i]) begin
			request(bad[i][23:16], bad[i][15:8], {bad[i][7:0], 8'h00}, 16'h0, 16'h0012);
			check("stall", st, 1);
		end
		request(RT_DEV_IN, RQ_GET_DESC, 16'h0100, 16'h0, 16'h0012);
		check("device descriptor passed", descs, 1);
		request(RT_DEV_IN, 8'h00, 16'h0, 16'h0, 16'h0002);
		check("other request passed", reqs, 1);
		$display("test requests done");
		request(RT_DEV_IN, RQ_GET_DESC, 16'h0301, 16'h0409, 16'h00FF);
		check("string count", far.got.size(), 6);
		foreach (s[i]) check("string byte", far.got[i], s[i]);
		request(RT_DEV_IN, RQ_GET_DESC, 16'h0302, 16'h0409, 16'h00FF);
		check("empty string stall", st, 1);
		ee_present <= 1'b0;
		request(RT_DEV_IN, RQ_GET_DESC, 16'h0301, 16'h0409, 16'h00FF);
		check("no memory stall", st + far.got.size(), 1);
		$display("test strings done");
		rx(14'd100, 4'b0000);
		rx(14'd100, 4'b0001);
		rx(14'd40, 4'b0001);
		rx(14'd100, 4'b0011);
		rx(14'd1600, 4'b0000);
		rx(14'd100, 4'b0100);
		rx(14'd100, 4'b1001);
		rx(14'd100, 4'b1000);
		rx_phy_err <= 1'b1;
		rx(14'd100, 4'b0000);
		rx_phy_err <= 1'b0;
		for (int c = 0; c < 4; c++) tx(c[4:0], 6'b0);
		for (int b = 0; b < 6; b++) tx(5'h0, 6'(1 << b));
		slow <= 1'b1;
		stats(1'b0, '{2, 2, 1, 1, 1, 1, 6, 2, 0, 0});
		stats(1'b1, '{5, 1, 1, 2, 1, 1, 1, 1, 1, 5});
		rx(14'd100, 4'b0000);
		stats(1'b0, '{3, 2, 1, 1, 1, 1, 6, 2, 0, 0});
		$display("test statistics done");
		complete_run();
	end
	initial begin
		#200000;
		fails++;
		complete_run();
	end
endmodule
`default_nettype wire

// File: verification/usbcs_ctl_props.sv
// port assertions for the request and statistics block
`timescale 1ns/100ps
`default_nettype none
module usbcs_ctl_props
	import usbcs_pkg::*;
#(parameter int EE_AW = 9) (
	input wire logic             clk,
	input wire logic             rst_n,
	input wire logic             setup_valid,
	input wire logic [7:0]       bm_request_type,
	input wire logic [7:0]       b_request,
	input wire logic [15:0]      w_value,
	input wire logic [15:0]      w_index,
	input wire logic [15:0]      w_length,
	input wire logic             busy,
	input wire logic             stall_pulse,
	input wire logic             ack_pulse,
	input wire logic             data_valid,
	input wire logic             data_last,
	input wire logic             data_ready,
	input wire logic             ee_present,
	input wire logic             ee_rd,
	input wire logic [EE_AW-1:0] ee_addr,
	input wire logic             reg_wr,
	input wire logic             remote_wakeup_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic             take;  // setup accepted this edge
	logic             gdesc; // standard get descriptor
	logic             sidx;  // string index one to five
	logic [EE_AW-1:0] str_a; // table slot of that index
	assign take = setup_valid && !busy;
	assign gdesc = take && bm_request_type == RT_DEV_IN && b_request == RQ_GET_DESC;
	assign sidx = w_value[15:8] == DT_STRING && w_value[7:0] != 8'h00 && w_value[7:0] <= STR_IDX_MAX;
	assign str_a = EE_AW'(STR_TBL_BASE + {w_value[7:0] - 8'h01, 1'b0});
	last_closes_a: assert property (data_last && data_ready |=> !data_valid && ack_pulse)
		else $error("last byte not closed");
	cfg_answer_a: assert property (take && bm_request_type == RT_DEV_IN
		&& b_request == RQ_GET_CFG && w_length != 16'h0000 |=> data_valid && data_last)
		else $error("config byte late");
	wake_clear_a: assert property (take && bm_request_type == RT_DEV_OUT
		&& b_request == RQ_CLR_FEAT && w_length == 16'h0000 && !reg_wr
		|=> ack_pulse ##[0:1] !remote_wakeup_en) else $error("wakeup kept");
	halt_clear_a: assert property (take && bm_request_type == RT_EP_OUT
		&& b_request == RQ_CLR_FEAT && w_length == 16'h0000 && w_index[3:0] < NUM_EP
		|=> ack_pulse) else $error("endpoint clear not acked");
	unsup_stall_a: assert property (take && ((bm_request_type == RT_DEV_OUT
		&& b_request == RQ_SET_DESC) || (bm_request_type == RT_EP_IN && b_request == RQ_SYNCH))
		|=> stall_pulse) else $error("unsupported request not stalled");
	iface_stall_a: assert property (gdesc
		&& (w_value[15:8] == DT_IFACE || w_value[15:8] == DT_EP)
		|=> stall_pulse) else $error("interface or endpoint descriptor served");
	nostr_stall_a: assert property (gdesc && sidx && !ee_present |-> ##[1:4] stall_pulse)
		else $error("absent string not stalled");
	str_fetch_a: assert property (gdesc && sidx && ee_present
		|=> ee_rd && ee_addr == $past(str_a)) else $error("string table slot wrong");
	stats_answer_a: assert property (take && bm_request_type == RT_VND_IN
		&& b_request == RQ_GET_STATS && w_length != 16'h0000 |-> ##2 data_valid)
		else $error("statistics data late");
	one_verdict_a: assert property (!(stall_pulse && ack_pulse)) else $error("stall and ack");
	cover property (take && b_request == RQ_GET_STATS);
	cover property (gdesc && sidx && ee_present);
	cover property (stall_pulse);
	cover property (data_valid && data_last);
endmodule
bind usbcs_ctl usbcs_ctl_props #(.EE_AW(EE_AW)) props (.*);
`default_nettype wire

// File: verification/usbcs_far_model.sv
// host data consumer and string memory beside the block
`timescale 1ns/100ps
`default_nettype none
module usbcs_far_model #(parameter int EE_AW = 9) (
	input wire logic             clk,
	input wire logic             ee_rd,
	input wire logic [EE_AW-1:0] ee_addr,
	output logic      [7:0]       ee_rdata,
	input wire logic             data_valid,
	input wire logic [7:0]       data_byte,
	input wire logic             slow,
	output logic                 data_ready
);
	logic [7:0] mem [0:(1<<EE_AW)-1]; // string bytes, loaded by the bench
	logic [7:0] got [$];              // bytes taken from the data stage
	logic       tog = 1'b0;           // paces a slow host
	// byte stands while the strobe stands, otherwise no stale value
	assign ee_rdata = ee_rd ? mem[ee_addr] : ~mem[ee_addr];
	always @(posedge clk) begin
		tog <= ~tog;
		if (data_valid && data_ready)
			got.push_back(data_byte);
	end
	assign data_ready = !slow || tog;
endmodule
`default_nettype wire
